//--- common/sac_pkg.sv
// Constants for the successive-approximation converter control block
package sac_pkg;
    // I/O memory addresses
    localparam logic [15:0] ADDR_SUPPLY_SELECT = 16'hff01;
    localparam logic [15:0] ADDR_CONV_CONTROL = 16'hffd0;
    localparam logic [15:0] ADDR_ANALOG_PIN_ENABLES = 16'hffd1;
    localparam logic [15:0] ADDR_RESULT_LOW_NIBBLE = 16'hffd2;
    localparam logic [15:0] ADDR_RESULT_HIGH_NIBBLE = 16'hffd3;
    localparam logic [15:0] ADDR_DONE_IRQ_ENABLE = 16'hffe7;
    localparam logic [15:0] ADDR_DONE_FLAG = 16'hfff7;

    // Field positions
    localparam int BIT_CHANNEL_SELECT_LSB = 0;
    localparam int BIT_CHANNEL_SELECT_MSB = 1;
    localparam int BIT_CONV_CLOCK_SELECT = 2;
    localparam int BIT_CONV_START = 3;
    localparam int BIT_OSC_REGULATOR_SUPPLY = 2;
    localparam int BIT_CONV_SUPPLY_SELECT = 3;
    localparam int BIT_DONE_IRQ_ENABLE = 0;
    localparam int BIT_DONE_FLAG = 0;

    // Reset values
    localparam logic [3:0] RESET_NIBBLE = 4'h0;
    localparam logic [1:0] RESET_CHANNEL = 2'h0;
    localparam logic RESET_BIT = 1'b0;

    // Interrupt vector of conversion completion
    localparam logic [15:0] DONE_VECTOR = 16'h010e;

    // Conversion timing; derived counts are in conversion clock ticks
    localparam int SAR_BITS = 8;
    localparam int CONV_TIME_US = 21;
    localparam int CONV_CLK_MAX_KHZ = 1000;
    localparam int CONV_TICKS = CONV_TIME_US * CONV_CLK_MAX_KHZ / 1000;
    localparam int STORE_TICKS = 1;
    localparam int SAMPLE_TICKS = CONV_TICKS - SAR_BITS - STORE_TICKS;
    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_TICKS - 1);
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;

    // Number of synchronised asynchronous inputs and their bit positions
    localparam int SYNC_INPUTS = 3;
    localparam int SYNC_LOW_OSC = 0;
    localparam int SYNC_HIGH_OSC = 1;
    localparam int SYNC_COMPARE = 2;

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_SAMPLE,
        SAC_RESOLVE,
        SAC_STORE
    } sac_state_t;
endpackage

//--- common/sac_conv_if.sv
// Link between the register side and the approximation engine
`timescale 1ns/10ps
interface sac_conv_if;
    logic tick;
    logic start;
    logic busy;
    logic sampling;
    logic done;
    logic compare;
    logic [7:0] trial;
    logic [7:0] result;

    modport ctrl (
        output tick,
        output start,
        output compare,
        input busy,
        input sampling,
        input done,
        input trial,
        input result
    );

    modport engine (
        input tick,
        input start,
        input compare,
        output busy,
        output sampling,
        output done,
        output trial,
        output result
    );
endinterface

//--- logic/sac_engine.sv
// Sample phase and bitwise approximation sequencer
`timescale 1ns/10ps
module sac_engine (
    input wire logic clk_in,
    input wire logic rst_in,
    sac_conv_if.engine conv
);
    sac_pkg::sac_state_t state;
    sac_pkg::sac_state_t next_state;
    logic [3:0] count;
    logic [7:0] trial;
    logic [7:0] result;
    logic [7:0] mask;
    logic done;

    wire sample_end = conv.tick && state == sac_pkg::SAC_SAMPLE
        && count == sac_pkg::SAMPLE_LAST;
    wire bit_step = conv.tick && state == sac_pkg::SAC_RESOLVE;
    wire last_bit = mask == 8'h01;
    // Comparator high means input is at or above the trial level
    wire [7:0] kept = conv.compare ? trial : (trial & ~mask);

    always_comb begin
        next_state = state;
        case (state)
            sac_pkg::SAC_IDLE: begin
                if (conv.start) begin
                    next_state = sac_pkg::SAC_SAMPLE;
                end
            end
            sac_pkg::SAC_SAMPLE: begin
                if (sample_end) begin
                    next_state = sac_pkg::SAC_RESOLVE;
                end
            end
            sac_pkg::SAC_RESOLVE: begin
                if (bit_step && last_bit) begin
                    next_state = sac_pkg::SAC_STORE;
                end
            end
            sac_pkg::SAC_STORE: begin
                if (conv.tick) begin
                    next_state = sac_pkg::SAC_IDLE;
                end
            end
            default: begin
                next_state = sac_pkg::SAC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state <= sac_pkg::SAC_IDLE;
            count <= 4'h0;
            trial <= 8'h00;
            mask <= 8'h00;
            done <= 1'b0;
        end else begin
            state <= next_state;
            done <= conv.tick && state == sac_pkg::SAC_STORE;
            if (state == sac_pkg::SAC_IDLE) begin
                count <= 4'h0;
            end else if (conv.tick && state == sac_pkg::SAC_SAMPLE) begin
                count <= count + 4'h1;
            end
            if (sample_end) begin
                trial <= sac_pkg::SAR_FIRST_TRIAL;
                mask <= sac_pkg::SAR_FIRST_TRIAL;
            end else if (bit_step) begin
                trial <= kept | (mask >> 1);
                mask <= mask >> 1;
            end
        end
    end

    // Result holds no reset value until the first conversion ends
    always_ff @(posedge clk_in) begin
        if (bit_step && last_bit) begin
            result <= kept;
        end
    end

    assign conv.busy = state != sac_pkg::SAC_IDLE;
    assign conv.sampling = state == sac_pkg::SAC_SAMPLE;
    assign conv.done = done;
    assign conv.trial = trial;
    assign conv.result = result;

    // Ticks seen since the start, for the timing check
    logic [5:0] tick_seen;
    always_ff @(posedge clk_in) begin
        if (rst_in || state == sac_pkg::SAC_IDLE) begin
            tick_seen <= 6'h00;
        end else if (conv.tick) begin
            tick_seen <= tick_seen + 6'h01;
        end
    end

    AST_MIN_CONV_TICKS: assert property (@(posedge clk_in)
        disable iff (rst_in)
        conv.tick && state == sac_pkg::SAC_STORE
        |-> tick_seen == 6'(sac_pkg::CONV_TICKS - 1))
        else $error("conversion ended before its tick count");

    AST_MSB_FIRST: assert property (@(posedge clk_in)
        disable iff (rst_in)
        sample_end |=> trial == 8'h80 && state == sac_pkg::SAC_RESOLVE)
        else $error("approximation did not open at the top bit");
endmodule

//--- logic/sac_control.sv
// Register file, clock selector and pin control of the converter
`timescale 1ns/10ps

// Behaviour
// - Finished conversion readable by the CPU as an 8-bit unsigned value.
// - One conversion takes at least 21 ticks of a 1 MHz conversion clock.
// - Each shared pin is analog input when its enable is 1, else port.
// - Reset clears all analog enables; shared pins become port pins.
// - Select 0 takes the low-speed oscillator, 1 the high-speed one halved.
// - Conversion clock starts passing when software writes 1 to start.
// - Two-bit channel select picks analog input 0 to 3.
// - Writing 1 to bit 3 at FFD0 starts converting the selected channel.
// - Start waits a sampling delay, holds, then resolves eight bits.
// - Result bit 0 is the LSB; low nibble FFD2, high nibble FFD3.
// - Done flag sets one conversion tick after the result is stored, mask aside.
// - Interrupt request while done flag and its enable are both 1.
// - Writing 1 to the done flag clears it.
// - Completion interrupt uses vector 010E.
// - Supply select bit 3 at FF01 is read-write, resets to 0.
// - Result content is undefined until the first conversion ends.
// - Start bit is write-only; writing 0 does nothing.
module sac_control (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [3:0] io_wdata_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    output logic [3:0] io_rdata_out,
    input wire logic low_speed_osc_in,
    input wire logic high_speed_osc_in,
    input wire logic compare_in,
    output logic [7:0] dac_code_out,
    output logic sample_hold_out,
    output logic [1:0] channel_select_out,
    output logic [3:0] analog_pin_enable_out,
    input wire logic [3:0] port_oe_in,
    output logic [3:0] shared_port_pins_oe_out,
    output logic conv_supply_select_out,
    output logic osc_regulator_supply_select_out,
    output logic conv_busy_out,
    output logic irq_out,
    output logic [15:0] irq_vector_out
);
    sac_conv_if conv ();

    sac_engine u_engine (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .conv(conv)
    );

    // Control state
    logic [3:0] analog_pin_enable;
    logic channel_select_lsb;
    logic channel_select_msb;
    logic conv_clock_select;
    logic conv_supply_select;
    logic osc_regulator_supply_select;
    logic conv_done_irq_enable;
    logic conv_done_flag;
    logic conv_clock_on;
    logic high_osc_half;
    logic [3:0] rdata;

    // Three-stage synchronisers with agreement filter
    logic [sac_pkg::SYNC_INPUTS-1:0] sync_a;
    logic [sac_pkg::SYNC_INPUTS-1:0] sync_b;
    logic [sac_pkg::SYNC_INPUTS-1:0] sync_c;
    logic [sac_pkg::SYNC_INPUTS-1:0] level;
    logic [sac_pkg::SYNC_INPUTS-1:0] rise;
    wire [sac_pkg::SYNC_INPUTS-1:0] raw_in =
        {compare_in, high_speed_osc_in, low_speed_osc_in};

    genvar gi;
    generate
        for (gi = 0; gi < sac_pkg::SYNC_INPUTS; gi++) begin : g_sync
            assign rise[gi] = sync_b[gi] && sync_c[gi] && !level[gi];
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                    level[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                    if (sync_b[gi] == sync_c[gi]) begin
                        level[gi] <= sync_c[gi];
                    end
                end
            end
        end
    endgenerate

    // Port drivers are released on pins given to the converter
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            assign shared_port_pins_oe_out[gi] =
                port_oe_in[gi] && !analog_pin_enable[gi];
        end
    endgenerate

    // Write and read decode
    wire hit_supply = io_addr_in == sac_pkg::ADDR_SUPPLY_SELECT;
    wire hit_control = io_addr_in == sac_pkg::ADDR_CONV_CONTROL;
    wire hit_pins = io_addr_in == sac_pkg::ADDR_ANALOG_PIN_ENABLES;
    wire hit_low = io_addr_in == sac_pkg::ADDR_RESULT_LOW_NIBBLE;
    wire hit_high = io_addr_in == sac_pkg::ADDR_RESULT_HIGH_NIBBLE;
    wire hit_enable = io_addr_in == sac_pkg::ADDR_DONE_IRQ_ENABLE;
    wire hit_flag = io_addr_in == sac_pkg::ADDR_DONE_FLAG;

    wire wr_supply = io_wr_in && hit_supply;
    wire wr_control = io_wr_in && hit_control;
    wire wr_pins = io_wr_in && hit_pins;
    wire wr_enable = io_wr_in && hit_enable;
    wire wr_flag = io_wr_in && hit_flag;

    wire start_write = wr_control && io_wdata_in[sac_pkg::BIT_CONV_START];
    // A start during a conversion is dropped, the running one completes
    wire start_go = start_write && !conv.busy;
    wire flag_clear = wr_flag && io_wdata_in[sac_pkg::BIT_DONE_FLAG];

    // Start bit always reads back as zero
    wire [3:0] read_control = {1'b0, conv_clock_select,
        channel_select_msb, channel_select_lsb};
    wire [3:0] read_supply = {conv_supply_select,
        osc_regulator_supply_select, 2'b00};
    wire [3:0] read_mux =
        hit_supply ? read_supply :
        hit_control ? read_control :
        hit_pins ? analog_pin_enable :
        hit_low ? conv.result[3:0] :
        hit_high ? conv.result[7:4] :
        hit_enable ? {3'b000, conv_done_irq_enable} :
        hit_flag ? {3'b000, conv_done_flag} :
        4'h0;

    // Conversion clock selector; high oscillator is halved
    wire high_tick = rise[sac_pkg::SYNC_HIGH_OSC] && high_osc_half;
    wire low_tick = rise[sac_pkg::SYNC_LOW_OSC];
    wire selected_tick = conv_clock_select ? high_tick : low_tick;
    // Edges faster than a few MHz are lost to sampling at 20 MHz
    assign conv.tick = conv_clock_on && selected_tick;
    assign conv.start = start_go;
    assign conv.compare = level[sac_pkg::SYNC_COMPARE];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            analog_pin_enable <= sac_pkg::RESET_NIBBLE;
            conv_supply_select <= sac_pkg::RESET_BIT;
            osc_regulator_supply_select <= sac_pkg::RESET_BIT;
            conv_done_irq_enable <= sac_pkg::RESET_BIT;
        end else begin
            if (wr_pins) begin
                analog_pin_enable <= io_wdata_in;
            end
            if (wr_supply) begin
                conv_supply_select <=
                    io_wdata_in[sac_pkg::BIT_CONV_SUPPLY_SELECT];
                osc_regulator_supply_select <=
                    io_wdata_in[sac_pkg::BIT_OSC_REGULATOR_SUPPLY];
            end
            if (wr_enable) begin
                conv_done_irq_enable <=
                    io_wdata_in[sac_pkg::BIT_DONE_IRQ_ENABLE];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            channel_select_lsb <= sac_pkg::RESET_CHANNEL[0];
            channel_select_msb <= sac_pkg::RESET_CHANNEL[1];
            conv_clock_select <= sac_pkg::RESET_BIT;
        end else if (wr_control) begin
            channel_select_lsb <=
                io_wdata_in[sac_pkg::BIT_CHANNEL_SELECT_LSB];
            channel_select_msb <=
                io_wdata_in[sac_pkg::BIT_CHANNEL_SELECT_MSB];
            conv_clock_select <=
                io_wdata_in[sac_pkg::BIT_CONV_CLOCK_SELECT];
        end
    end

    // Clock gate opens on start and closes once the result is stored
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            conv_clock_on <= 1'b0;
            high_osc_half <= 1'b0;
        end else begin
            if (start_go) begin
                conv_clock_on <= 1'b1;
            end else if (conv.done) begin
                conv_clock_on <= 1'b0;
            end
            if (start_go) begin
                high_osc_half <= 1'b0;
            end else if (rise[sac_pkg::SYNC_HIGH_OSC]) begin
                high_osc_half <= !high_osc_half;
            end
        end
    end

    // Completion sets the flag even when masked; set beats clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            conv_done_flag <= 1'b0;
        end else if (conv.done) begin
            conv_done_flag <= 1'b1;
        end else if (flag_clear) begin
            conv_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata <= 4'h0;
        end else if (io_rd_in) begin
            rdata <= read_mux;
        end
    end

    assign io_rdata_out = rdata;
    assign dac_code_out = conv.trial;
    assign sample_hold_out = conv.sampling;
    assign channel_select_out =
        {channel_select_msb, channel_select_lsb};
    assign analog_pin_enable_out = analog_pin_enable;
    assign conv_supply_select_out = conv_supply_select;
    assign osc_regulator_supply_select_out = osc_regulator_supply_select;
    assign conv_busy_out = conv.busy;
    assign irq_out = conv_done_flag && conv_done_irq_enable;
    assign irq_vector_out = sac_pkg::DONE_VECTOR;

    AST_IRQ_GATED: assert property (@(posedge clk_in)
        disable iff (rst_in)
        conv.done && conv_done_irq_enable && !wr_enable |=> irq_out)
        else $error("interrupt request not raised on enabled completion");

    AST_DONE_SETS_FLAG: assert property (@(posedge clk_in)
        disable iff (rst_in)
        conv.done |=> conv_done_flag)
        else $error("done flag not set after result store");

    AST_FLAG_CLEAR: assert property (@(posedge clk_in)
        disable iff (rst_in)
        flag_clear && !conv.done |=> !conv_done_flag)
        else $error("done flag not cleared by writing one");

    AST_PINS_RESET: assert property (@(posedge clk_in)
        rst_in |=> analog_pin_enable_out == 4'h0
            && shared_port_pins_oe_out == port_oe_in)
        else $error("analog enables not cleared by reset");

    AST_SUPPLY_RESET: assert property (@(posedge clk_in)
        rst_in |=> !conv_supply_select_out)
        else $error("supply select not cleared by reset");

    AST_START_RUNS: assert property (@(posedge clk_in)
        disable iff (rst_in)
        start_write && !conv_busy_out |=> conv_busy_out && conv_clock_on)
        else $error("start write did not begin a conversion");

    AST_START_IGNORED: assert property (@(posedge clk_in)
        disable iff (rst_in)
        start_write && conv_busy_out && !rise[sac_pkg::SYNC_HIGH_OSC]
        |=> $stable(high_osc_half) && !conv.sampling)
        else $error("start during conversion disturbed the selector");

    AST_TICK_GATED: assert property (@(posedge clk_in)
        disable iff (rst_in)
        conv.tick |-> conv_clock_on && conv_busy_out)
        else $error("conversion tick outside a running conversion");

    AST_LOW_SOURCE: assert property (@(posedge clk_in)
        disable iff (rst_in)
        conv.tick && !conv_clock_select |-> rise[sac_pkg::SYNC_LOW_OSC])
        else $error("tick not from low-speed oscillator");

    AST_RESULT_READ: assert property (@(posedge clk_in)
        disable iff (rst_in)
        io_rd_in && hit_high |=> io_rdata_out == $past(conv.result[7:4]))
        else $error("high result nibble misread");
endmodule

//--- tb/sac_analog_model.sv
// Analog side model: oscillators, shared input pins and comparator
`timescale 1ns/10ps
module sac_analog_model (
    input wire logic clk_in,
    input wire logic [7:0] dac_code_in,
    input wire logic sample_hold_in,
    input wire logic [1:0] channel_select_in,
    input wire logic [3:0] analog_pin_enable_in,
    input wire logic [31:0] vin_in,
    output logic compare_out,
    output logic low_speed_osc_out,
    output logic high_speed_osc_out
);
    logic [7:0] held = 8'h00;
    logic noise = 1'b0;
    wire logic [7:0] pin_level = vin_in[8*channel_select_in +: 8];
    wire logic pin_analog = analog_pin_enable_in[channel_select_in];
    // Low source 800 kHz, high source 2 MHz: both give at most 1 MHz
    initial begin
        low_speed_osc_out = 1'b0;
        #311;
        forever #625 low_speed_osc_out = ~low_speed_osc_out;
    end
    initial begin
        high_speed_osc_out = 1'b0;
        #97;
        forever #250 high_speed_osc_out = ~high_speed_osc_out;
    end
    always_ff @(posedge clk_in) begin
        noise <= ~noise;
        if (sample_hold_in) begin
            held <= pin_level;
        end
    end
    // A pin left as port gives the comparator nothing usable
    assign compare_out = pin_analog ? (held >= dac_code_in) : noise;
endmodule

//--- tb/sac_control_bench.sv
// Self-checking bench of the converter control block
`timescale 1ns/10ps
module sac_control_bench;
    typedef struct packed {
        logic [1:0] ch;
        logic clk_sel;
        logic irq_en;
        logic [7:0] level;
    } sac_row_t;
    localparam int ROWS = 6;
    localparam sac_row_t TABLE [ROWS] = '{
        '{2'h0, 1'b0, 1'b1, 8'h00}, '{2'h1, 1'b1, 1'b0, 8'hff},
        '{2'h2, 1'b0, 1'b1, 8'h80}, '{2'h3, 1'b1, 1'b1, 8'h5a},
        '{2'h0, 1'b1, 1'b0, 8'h7f}, '{2'h3, 1'b0, 1'b0, 8'ha5}};
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [15:0] io_addr_in = 16'h0000;
    logic [3:0] io_wdata_in = 4'h0;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [3:0] port_oe_in = 4'h6;
    logic [31:0] vin = 32'h0000_0000;
    logic [3:0] rdata, analog_en, pin_oe;
    logic [7:0] dac_code;
    logic [1:0] channel_select;
    logic [15:0] irq_vector;
    logic sample_hold, supply_sel, osc_reg_sel, busy, irq;
    logic low_osc, high_osc, compare;
    int fail_count = 0;
    int total_checks = 0;

    sac_control uut (.clk_in(clk_in), .rst_in(rst_in),
        .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
        .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_rdata_out(rdata),
        .low_speed_osc_in(low_osc), .high_speed_osc_in(high_osc),
        .compare_in(compare), .dac_code_out(dac_code),
        .sample_hold_out(sample_hold), .channel_select_out(channel_select),
        .analog_pin_enable_out(analog_en), .port_oe_in(port_oe_in),
        .shared_port_pins_oe_out(pin_oe), .conv_supply_select_out(supply_sel),
        .osc_regulator_supply_select_out(osc_reg_sel),
        .conv_busy_out(busy), .irq_out(irq), .irq_vector_out(irq_vector));

    sac_analog_model far_side (.clk_in(clk_in), .dac_code_in(dac_code),
        .sample_hold_in(sample_hold), .channel_select_in(channel_select),
        .analog_pin_enable_in(analog_en), .vin_in(vin),
        .compare_out(compare), .low_speed_osc_out(low_osc),
        .high_speed_osc_out(high_osc));

    initial begin
        forever #25 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic io_write(input logic [15:0] a, input logic [3:0] d);
        @(posedge clk_in);
        io_addr_in <= a;
        io_wdata_in <= d;
        io_wr_in <= 1'b1;
        @(posedge clk_in);
        io_wr_in <= 1'b0;
    endtask

    task automatic expect_reg(input string what, input logic [15:0] a,
        input logic [3:0] exp);
        @(posedge clk_in);
        io_addr_in <= a;
        io_rd_in <= 1'b1;
        @(posedge clk_in);
        io_rd_in <= 1'b0;
        #1;
        check(what, {12'h000, exp}, {12'h000, rdata});
    endtask

    task automatic chk_reset();
        expect_reg("conv_control", sac_pkg::ADDR_CONV_CONTROL, 4'h0);
        expect_reg("pin_en", sac_pkg::ADDR_ANALOG_PIN_ENABLES, 4'h0);
        expect_reg("supply", sac_pkg::ADDR_SUPPLY_SELECT, 4'h0);
        expect_reg("irq_en", sac_pkg::ADDR_DONE_IRQ_ENABLE, 4'h0);
        expect_reg("done_flag", sac_pkg::ADDR_DONE_FLAG, 4'h0);
        check("pin_oe", {12'h000, port_oe_in}, {12'h000, pin_oe});
        check("analog_en", 16'h0000, {12'h000, analog_en});
        check("busy_irq", 16'h0000, {14'h0000, busy, irq});
    endtask

    // Elapsed cycles bounded by tick count; start phase against the
    // free-running source leaves up to one tick of slack
    task automatic run_conv(input sac_row_t r, input logic again);
        int n;
        int lo;
        lo = r.clk_sel ? 400 : 500;
        vin[8*r.ch +: 8] = r.level;
        io_write(sac_pkg::ADDR_CONV_CONTROL, {1'b1, r.clk_sel, r.ch});
        @(posedge clk_in);
        #1;
        check("busy_sample", 16'h0003, {14'h0000, busy, sample_hold});
        n = 2;
        while (sample_hold === 1'b1 && n < 1000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("first_trial", 16'h0080, {8'h00, dac_code});
        if (again) begin
            vin[8*r.ch +: 8] = ~r.level;
            io_write(sac_pkg::ADDR_CONV_CONTROL, {1'b1, r.clk_sel, r.ch});
            #1;
            n += 2;
        end
        while (busy === 1'b1 && n < 1000) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("conv_time", 16'h0001,
            {15'h0000, n >= lo && n <= lo + 45});
        repeat (3) @(posedge clk_in);
        #1;
        check("irq", {15'h0000, r.irq_en}, {15'h0000, irq});
        expect_reg("done_flag", sac_pkg::ADDR_DONE_FLAG, 4'h1);
        expect_reg("res_lo", sac_pkg::ADDR_RESULT_LOW_NIBBLE,
            r.level[3:0]);
        expect_reg("res_hi", sac_pkg::ADDR_RESULT_HIGH_NIBBLE,
            r.level[7:4]);
    endtask

    initial begin
        #1000000;
        fail_count++;
        $display("ERROR watchdog expected finish seen timeout");
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        chk_reset();
        @(posedge clk_in);
        port_oe_in <= 4'hf;
        io_write(sac_pkg::ADDR_ANALOG_PIN_ENABLES, 4'h5);
        expect_reg("pin_en", sac_pkg::ADDR_ANALOG_PIN_ENABLES, 4'h5);
        check("pin_oe", 16'h000a, {12'h000, pin_oe});
        check("analog_en", 16'h0005, {12'h000, analog_en});
        io_write(sac_pkg::ADDR_SUPPLY_SELECT, 4'hf);
        expect_reg("supply", sac_pkg::ADDR_SUPPLY_SELECT, 4'hc);
        check("supply_outs", 16'h0003,
            {14'h0000, supply_sel, osc_reg_sel});
        io_write(sac_pkg::ADDR_DONE_IRQ_ENABLE, 4'hf);
        expect_reg("irq_en", sac_pkg::ADDR_DONE_IRQ_ENABLE, 4'h1);
        expect_reg("unmapped", 16'hffd4, 4'h0);
        check("vector", 16'h010e, irq_vector);
        io_write(sac_pkg::ADDR_CONV_CONTROL, 4'h7);
        repeat (3) @(posedge clk_in);
        #1;
        check("no_start", 16'h0003, {13'h0000, busy, channel_select});
        expect_reg("conv_control", sac_pkg::ADDR_CONV_CONTROL, 4'h7);
        io_write(sac_pkg::ADDR_ANALOG_PIN_ENABLES, 4'hf);
        for (int i = 0; i < ROWS; i++) begin
            io_write(sac_pkg::ADDR_DONE_IRQ_ENABLE, {3'h0, TABLE[i].irq_en});
            run_conv(TABLE[i], 1'b0);
            check("channel", {14'h0000, TABLE[i].ch},
                {14'h0000, channel_select});
            io_write(sac_pkg::ADDR_DONE_FLAG, 4'h1);
            expect_reg("flag_clr", sac_pkg::ADDR_DONE_FLAG, 4'h0);
            check("irq_clr", 16'h0000, {15'h0000, irq});
        end
        io_write(sac_pkg::ADDR_DONE_IRQ_ENABLE, 4'h1);
        run_conv(sac_row_t'{2'h2, 1'b1, 1'b1, 8'h3c}, 1'b1);
        io_write(sac_pkg::ADDR_DONE_FLAG, 4'h0);
        expect_reg("flag_kept", sac_pkg::ADDR_DONE_FLAG, 4'h1);
        expect_reg("start_rd", sac_pkg::ADDR_CONV_CONTROL, 4'h6);
        io_write(sac_pkg::ADDR_DONE_IRQ_ENABLE, 4'h0);
        @(posedge clk_in);
        #1;
        check("irq_masked", 16'h0000, {15'h0000, irq});
        expect_reg("flag_masked", sac_pkg::ADDR_DONE_FLAG, 4'h1);
        // Second reset in mid-run must bring every control bit back
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        chk_reset();
        close_out();
    end
endmodule
